// ### hdl/jhp_host_port.sv
/*
 * Strobe-timed 8-bit host register port of a boundary-scan bus master:
 * eight registers, wait-state generation and the scan data buffers.
 * Assumes the host keeps direction and address stable while the strobe is
 * low, and that the scan core beside it drives the core-side ports.
 */
// Summary of operation
// - Eight-bit data bus, three address lines.
// - Addresses 000 to 111 select registers in order.
// - Strobe alone times accesses, not the clock.
// - Read drives bus from strobe fall; float otherwise.
// - Write keeps data drivers off.
// - Write address at fall, data at rise.
// - Blocked access holds ready low until clear.
// - Empty scan-in read stalls until data.
// - Full or resetting scan-out write stalls.
// - Running command stalls control and setup writes.
// - Soft reset command write never stalls.
// - Duplex lead of five stalls scan-out writes when retiming is set.
// - All readable; status and scan-in read-only.
// - Pin-drive writes during command are discarded.
// - Reserved bits read as zero.
// - Reset: secondary setup 80, others 00.
`timescale 1ns/10ps
module jhp_host_port
    import jhp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       access_strobe_n,
    input  wire logic       read_select,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] host_data_in,
    output logic      [7:0] host_data_out,
    output logic            host_data_oe,
    output logic            ready,
    output logic      [7:0] scan_out_data,
    output logic            scan_out_valid,
    input  wire logic       scan_out_ready,
    input  wire logic [7:0] scan_in_data,
    input  wire logic       scan_in_valid,
    output logic            scan_in_ready,
    input  wire logic       tx_resetting,
    input  wire logic       full_duplex_active,
    input  wire logic       command_done,
    input  wire logic       count_status_flag,
    input  wire logic [3:0] tap_state_field,
    output logic      [7:0] tap_setup_primary,
    output logic      [7:0] tap_setup_secondary,
    output logic      [7:0] operation_control,
    output logic      [7:0] cycle_count_port,
    output logic      [7:0] manual_pin_drive,
    output logic            soft_reset_pulse,
    output logic            cycle_count_write
);
    localparam int PW = 13;  // Strobe, direction, address and data.

    logic [PW-1:0] sync_s1;          // First stage, read only by stage two.
    logic [PW-1:0] sync_s2;          // Second stage.
    logic [PW-1:0] sync_s3;          // Third stage.
    logic          strobe_n_filt;    // Strobe level once stages agree.
    logic          strobe_fall;      // Access begins.
    logic          strobe_rise;      // Access ends.
    logic          lat_read;         // Direction of the open access.
    logic [2:0]    lat_addr;         // Register of the open access.
    logic [7:0]    s_data;           // Synchronised data pins.
    logic [7:0]    read_data;        // Byte presented on reads.
    logic [7:0]    next_read_data;
    logic          blocked;          // The open access must wait.
    logic          cmd_running;      // Opcode field is non-zero.
    logic          do_write;         // Write completes this cycle.
    logic          do_read;          // Read completes this cycle.
    logic [2:0]    duplex_lead;      // Scan-out writes ahead of scan-in reads.
    logic          lead_limited;
    logic          tx_in_ready;
    logic          rx_out_valid;
    logic [7:0]    rx_out_data;
    logic          rx_empty_flag;
    logic          rx_was_empty;     // Empty flag a cycle late; the read byte lags.
    logic          tx_full_flag;
    logic [7:0]    status_byte;

    // Three-flop synchronisers on every host pin; the host timing is free.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_s1 <= {1'b1, {(PW-1){1'b0}}};
            sync_s2 <= {1'b1, {(PW-1){1'b0}}};
            sync_s3 <= {1'b1, {(PW-1){1'b0}}};
        end else begin
            sync_s1 <= {access_strobe_n, read_select, reg_addr, host_data_in};
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
        end
    end

    assign s_data      = sync_s3[7:0];
    // A strobe change counts once stages two and three agree on it.
    assign strobe_fall = strobe_n_filt && !sync_s2[12] && !sync_s3[12];
    assign strobe_rise = !strobe_n_filt && sync_s2[12] && sync_s3[12];

    // Filtered strobe and the address and direction caught at its fall.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strobe_n_filt <= 1'b1;
            lat_read      <= 1'b0;
            lat_addr      <= 3'h0;
        end else begin
            if (strobe_fall) begin
                strobe_n_filt <= 1'b0;
                lat_read      <= sync_s3[11];
                lat_addr      <= sync_s3[10:8];
            end else if (strobe_rise) begin
                strobe_n_filt <= 1'b1;
            end
        end
    end

    assign cmd_running   = (operation_control[OPCODE_MSB:0] != 4'h0);
    assign rx_empty_flag = !rx_out_valid;
    assign tx_full_flag  = !tx_in_ready || tx_resetting;
    assign lead_limited  = full_duplex_active
                           && (tap_setup_secondary[RETIMING_MSB:0] != 4'h0)
                           && (duplex_lead >= DUPLEX_LEAD_MAX);

    // Decide whether the open access has to wait.
    always_comb begin
        blocked = 1'b0;
        if (lat_read) begin
            blocked = (lat_addr == ADDR_SCAN_IN) && (rx_empty_flag || rx_was_empty);
        end else begin
            unique case (lat_addr)
                ADDR_SCAN_OUT: begin
                    blocked = tx_full_flag || lead_limited;
                end
                ADDR_OP_CONTROL: begin
                    // Soft reset gets through even mid-command.
                    blocked = cmd_running && !s_data[SOFT_RESET_BIT];
                end
                ADDR_SETUP_PRIMARY, ADDR_SETUP_SECONDARY, ADDR_CYCLE_COUNT: begin
                    blocked = cmd_running;
                end
                ADDR_CTRL_STATE, ADDR_SCAN_IN, ADDR_MANUAL_PIN: begin
                    blocked = 1'b0;
                end
            endcase
        end
    end

    // Ready drops only while an open access is blocked.
    assign ready = !(!strobe_n_filt && blocked);

    // An access completes at the strobe rise; a forced rise while blocked
    // is dropped, since the host did not wait for the grant.
    assign do_write = strobe_rise && !lat_read && !blocked;
    assign do_read  = strobe_rise && lat_read && !blocked;

    // Drivers follow the pins directly so they turn on at the strobe fall.
    assign host_data_oe  = read_select && !access_strobe_n;
    assign host_data_out = read_data;

    assign status_byte = {rx_empty_flag, tx_full_flag, count_status_flag,
                          1'b0, tap_state_field};

    // Read mux; follows the pins when idle so data is fresh at the fall.
    always_comb begin
        logic [2:0] sel;
        sel = strobe_n_filt ? sync_s3[10:8] : lat_addr;
        unique case (sel)
            ADDR_SETUP_PRIMARY:   next_read_data = tap_setup_primary;
            ADDR_SETUP_SECONDARY: next_read_data = tap_setup_secondary;
            ADDR_CTRL_STATE:      next_read_data = status_byte;
            ADDR_OP_CONTROL:      next_read_data = operation_control;
            ADDR_SCAN_OUT:        next_read_data = scan_out_data;
            ADDR_SCAN_IN:         next_read_data = rx_out_data;
            ADDR_CYCLE_COUNT:     next_read_data = cycle_count_port;
            ADDR_MANUAL_PIN:      next_read_data = manual_pin_drive;
        endcase
    end

    // Read byte register; held in the cycle the access completes.
    always_ff @(posedge sys_clk) begin
        rx_was_empty <= rx_empty_flag;
        if (rst) begin
            read_data <= RST_READ_DATA;
        end else if (!do_read) begin
            read_data <= next_read_data;
        end
    end

    // Setup, counter and pin-drive registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tap_setup_primary   <= RST_SETUP_PRIMARY;
            tap_setup_secondary <= RST_SETUP_SECONDARY;
            cycle_count_port    <= RST_CYCLE_COUNT;
            manual_pin_drive    <= RST_MANUAL_PIN;
            cycle_count_write   <= 1'b0;
        end else begin
            cycle_count_write <= 1'b0;
            if (do_write) begin
                unique case (lat_addr)
                    ADDR_SETUP_PRIMARY: begin
                        tap_setup_primary <= s_data & MASK_PRIMARY;
                    end
                    ADDR_SETUP_SECONDARY: begin
                        tap_setup_secondary <= s_data & MASK_SECONDARY;
                    end
                    ADDR_CYCLE_COUNT: begin
                        cycle_count_port  <= s_data;
                        cycle_count_write <= 1'b1;
                    end
                    ADDR_MANUAL_PIN: begin
                        // Dropped while a command owns the pins.
                        if (!cmd_running) begin
                            manual_pin_drive <= s_data & MASK_MANUAL;
                        end
                    end
                    ADDR_CTRL_STATE, ADDR_OP_CONTROL, ADDR_SCAN_OUT, ADDR_SCAN_IN: begin
                        manual_pin_drive <= manual_pin_drive;
                    end
                endcase
            end
        end
    end

    // Command register: the core clears the opcode when done, and a host
    // write in the same cycle wins so a new command is not lost.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            operation_control <= RST_OP_CONTROL;
            soft_reset_pulse  <= 1'b0;
        end else begin
            soft_reset_pulse <= 1'b0;
            if (command_done) begin
                operation_control[OPCODE_MSB:0] <= 4'h0;
            end
            if (do_write && lat_addr == ADDR_OP_CONTROL) begin
                if (s_data[SOFT_RESET_BIT]) begin
                    // Soft reset aborts the command; the bit itself is a pulse.
                    operation_control <= RST_OP_CONTROL;
                    soft_reset_pulse  <= 1'b1;
                end else begin
                    operation_control <= s_data & MASK_OP_STORE;
                end
            end
        end
    end

    // Duplex lead counter; cleared outside full-duplex scans.
    always_ff @(posedge sys_clk) begin
        if (rst || !full_duplex_active) begin
            duplex_lead <= 3'h0;
        end else begin
            if (do_write && lat_addr == ADDR_SCAN_OUT
                && !(do_read && lat_addr == ADDR_SCAN_IN)) begin
                duplex_lead <= duplex_lead + 3'h1;
            end else if (do_read && lat_addr == ADDR_SCAN_IN && duplex_lead != 3'h0) begin
                duplex_lead <= duplex_lead - 3'h1;
            end
        end
    end

    // Scan-out path: host writes fill it, the core drains it.
    jhp_pair_buffer #(
        .WIDTH (8),
        .DEPTH (BUFFER_DEPTH)
    ) u_tx_buffer (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_data   (s_data),
        .in_valid  (do_write && lat_addr == ADDR_SCAN_OUT),
        .in_ready  (tx_in_ready),
        .out_data  (scan_out_data),
        .out_valid (scan_out_valid),
        .out_ready (scan_out_ready)
    );

    // Scan-in path: the core fills it, host reads drain it.
    jhp_pair_buffer #(
        .WIDTH (8),
        .DEPTH (BUFFER_DEPTH)
    ) u_rx_buffer (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_data   (scan_in_data),
        .in_valid  (scan_in_valid),
        .in_ready  (scan_in_ready),
        .out_data  (rx_out_data),
        .out_valid (rx_out_valid),
        .out_ready (do_read && lat_addr == ADDR_SCAN_IN)
    );

    // A write access seen at its completing edge.
    sequence s_primary_write;
        strobe_rise && !lat_read && !blocked && lat_addr == ADDR_SETUP_PRIMARY;
    endsequence

    property p_float_high;
        @(posedge sys_clk) disable iff (rst) access_strobe_n |-> !host_data_oe;
    endproperty
    a_float_high: assert property (p_float_high) else $error("Bus driven with strobe high.");

    property p_write_float;
        @(posedge sys_clk) disable iff (rst) !read_select |-> !host_data_oe;
    endproperty
    a_write_float: assert property (p_write_float) else $error("Bus driven in write.");

    property p_write_lands;
        @(posedge sys_clk) disable iff (rst)
            s_primary_write |=> tap_setup_primary == ($past(s_data) & MASK_PRIMARY);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("Write not stored.");

    property p_rx_stall;
        @(posedge sys_clk) disable iff (rst)
            !strobe_n_filt && lat_read && lat_addr == ADDR_SCAN_IN && !rx_out_valid |-> !ready;
    endproperty
    a_rx_stall: assert property (p_rx_stall) else $error("Empty read not stalled.");

    property p_tx_stall;
        @(posedge sys_clk) disable iff (rst)
            !strobe_n_filt && !lat_read && lat_addr == ADDR_SCAN_OUT && tx_resetting |-> !ready;
    endproperty
    a_tx_stall: assert property (p_tx_stall) else $error("Scan-out write not stalled.");

    property p_cmd_stall;
        @(posedge sys_clk) disable iff (rst)
            !strobe_n_filt && !lat_read && lat_addr == ADDR_SETUP_PRIMARY && cmd_running
            |-> !ready ##1 (strobe_n_filt || !ready || !cmd_running);
    endproperty
    a_cmd_stall: assert property (p_cmd_stall) else $error("Setup write during command.");

    property p_soft_reset;
        @(posedge sys_clk) disable iff (rst)
            !strobe_n_filt && !lat_read && lat_addr == ADDR_OP_CONTROL
            && s_data[SOFT_RESET_BIT] |-> ready;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("Soft reset stalled.");

    property p_lead_cap;
        @(posedge sys_clk) disable iff (rst) duplex_lead <= DUPLEX_LEAD_MAX;
    endproperty
    a_lead_cap: assert property (p_lead_cap) else $error("Duplex lead above five.");

    property p_reset_values;
        @(posedge sys_clk) $fell(rst) |->
            tap_setup_secondary == RST_SETUP_SECONDARY && operation_control == RST_OP_CONTROL;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("Bad reset value.");
endmodule

// ### hdl/jhp_pkg.sv
/*
 * Package of the host register port: register indexes, field positions,
 * reset values and small limits shared by the port and its buffers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package jhp_pkg;
    // Register indexes on the three address pins.
    localparam logic [2:0] ADDR_SETUP_PRIMARY   = 3'h0;
    localparam logic [2:0] ADDR_SETUP_SECONDARY = 3'h1;
    localparam logic [2:0] ADDR_CTRL_STATE      = 3'h2;
    localparam logic [2:0] ADDR_OP_CONTROL      = 3'h3;
    localparam logic [2:0] ADDR_SCAN_OUT        = 3'h4;
    localparam logic [2:0] ADDR_SCAN_IN         = 3'h5;
    localparam logic [2:0] ADDR_CYCLE_COUNT     = 3'h6;
    localparam logic [2:0] ADDR_MANUAL_PIN      = 3'h7;

    // Values after reset.
    localparam logic [7:0] RST_SETUP_PRIMARY   = 8'h00;
    localparam logic [7:0] RST_SETUP_SECONDARY = 8'h80;
    localparam logic [7:0] RST_OP_CONTROL      = 8'h00;
    localparam logic [7:0] RST_CYCLE_COUNT     = 8'h00;
    localparam logic [7:0] RST_MANUAL_PIN      = 8'h00;
    localparam logic [7:0] RST_READ_DATA       = 8'h00;

    // Field positions.
    localparam int RX_EMPTY_BIT      = 7;
    localparam int TX_FULL_BIT       = 6;
    localparam int COUNT_STATUS_BIT  = 5;
    localparam int SOFT_RESET_BIT    = 7;
    localparam int OPCODE_MSB        = 3;
    localparam int RETIMING_MSB      = 3;
    localparam int PRIMARY_USED_MSB  = 5;
    localparam int MANUAL_USED_MSB   = 3;

    // Writable bits; reserved positions stay zero.
    localparam logic [7:0] MASK_PRIMARY   = 8'h3f;
    localparam logic [7:0] MASK_SECONDARY = 8'hef;
    localparam logic [7:0] MASK_OP_STORE  = 8'h7f;
    localparam logic [7:0] MASK_MANUAL    = 8'h0f;

    // Largest lead of scan-out writes over scan-in reads in full duplex.
    localparam logic [2:0] DUPLEX_LEAD_MAX = 3'h5;

    // Pin synchroniser depth and buffer depth.
    localparam int SYNC_STAGES  = 3;
    localparam int BUFFER_DEPTH = 2;
endpackage

// ### hdl/jhp_pair_buffer.sv
/*
 * Small FIFO with valid and ready on both sides, used in the scan data paths.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module jhp_pair_buffer
    import jhp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = BUFFER_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    // The pointer arithmetic wraps naturally only for a power of two.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("Buffer depth must be a power of two of at least two.");
    end

    logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
    logic [AW-1:0]    wr_ptr;       // Next slot to fill.
    logic [AW-1:0]    rd_ptr;       // Oldest slot.
    logic [AW:0]      fill;         // Words held.
    logic             push;
    logic             pop;

    // Full and empty come straight from the fill count.
    assign in_ready  = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage is written without reset; only the pointers and fill count need a value.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointer and count bookkeeping.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule

// ### bench/jhp_host_model.sv
/*
 * Host processor model: strobe-timed register accesses with wait states.
 * Assumes ready and read data of the port are settled at falling edges.
 */
`timescale 1ns/10ps
module jhp_host_model (
    input  wire logic       sys_clk,
    input  wire logic       ready,
    input  wire logic [7:0] host_data_out,
    output logic            access_strobe_n,
    output logic            read_select,
    output logic      [2:0] reg_addr,
    output logic      [7:0] host_data_in
);
    // Idle bus: strobe high, the other lines never sit on a stale value.
    initial begin
        access_strobe_n = 1'b1;
        read_select     = 1'b1;
        reg_addr        = 3'h0;
        host_data_in    = 8'h00;
    end

    // One access; after lim stalled cycles the strobe rises anyway.
    task automatic access(
        input  logic       rd,
        input  logic [2:0] a,
        input  logic [7:0] d,
        input  int         lim,
        output logic [7:0] q,
        output logic       ok
    );
        int n;
        n = 0;
        @(negedge sys_clk);
        read_select = rd;
        reg_addr = a;
        host_data_in = rd ? ~host_data_in : d;
        access_strobe_n = 1'b0;
        // Direction and address stay put until the strobe rises.
        repeat (5) @(negedge sys_clk);
        while (ready !== 1'b1 && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        ok = (n < lim);
        q = host_data_out;
        access_strobe_n = 1'b1;
        // Write data is held well past the rise, as the port samples late.
        repeat (6) @(negedge sys_clk);
        read_select = 1'b1;
        reg_addr = ~a;
        host_data_in = ~host_data_in;
    endtask
endmodule

// ### bench/test_jhp_host_port.sv
/*
 * Self-checking bench of the host register port behind a host model.
 * Assumes the package, design and host model are compiled before it.
 */
`timescale 1ns/10ps
module test_jhp_host_port
    import jhp_pkg::*;
;
    // Table row: address, byte written, byte read back.
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] q;
    } jhp_row_type;

    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       access_strobe_n;
    logic       read_select;
    logic [2:0] reg_addr;
    logic [7:0] host_data_in;
    logic [7:0] host_data_out;
    logic       host_data_oe;
    logic       ready;
    logic [7:0] scan_out_data;
    logic       scan_out_valid;
    logic       scan_out_ready = 1'b0;
    logic [7:0] scan_in_data = 8'h00;
    logic       scan_in_valid = 1'b0;
    logic       scan_in_ready;
    logic       tx_resetting = 1'b0;
    logic       full_duplex_active = 1'b0;
    logic       command_done = 1'b0;
    logic       soft_reset_pulse;
    logic       soft_seen = 1'b0;
    logic [7:0] rd_q;
    logic       ok;
    int         err_count = 0;
    int         num_checks = 0;
    int         stalls = 0;
    // Only legal setup encodings, zero in every reserved bit.
    jhp_row_type rows [7] = '{'{3'h0, 8'h2a, 8'h2a}, '{3'h1, 8'he5, 8'he5},
        '{3'h3, 8'h20, 8'h20}, '{3'h6, 8'h5a, 8'h5a}, '{3'h7, 8'h0f, 8'h0f},
        '{3'h2, 8'h00, 8'haa}, '{3'h0, 8'h11, 8'h11}};
    logic [2:0] rst_addr [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [7:0] rst_val  [6] = '{8'h00, 8'h80, 8'haa, 8'h00, 8'h00, 8'h00};

    always #10 sys_clk = ~sys_clk;

    // Status shows count flag set and a fixed state code.
    jhp_host_port dut_u (.sys_clk(sys_clk), .rst(rst), .access_strobe_n(access_strobe_n),
        .read_select(read_select), .reg_addr(reg_addr), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe), .ready(ready),
        .scan_out_data(scan_out_data), .scan_out_valid(scan_out_valid),
        .scan_out_ready(scan_out_ready), .scan_in_data(scan_in_data),
        .scan_in_valid(scan_in_valid), .scan_in_ready(scan_in_ready),
        .tx_resetting(tx_resetting), .full_duplex_active(full_duplex_active),
        .command_done(command_done), .count_status_flag(1'b1), .tap_state_field(4'ha),
        .tap_setup_primary(), .tap_setup_secondary(), .operation_control(),
        .cycle_count_port(), .manual_pin_drive(), .soft_reset_pulse(soft_reset_pulse),
        .cycle_count_write());

    jhp_host_model host_u (.sys_clk(sys_clk), .ready(ready), .host_data_out(host_data_out),
        .access_strobe_n(access_strobe_n), .read_select(read_select),
        .reg_addr(reg_addr), .host_data_in(host_data_in));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask

    task automatic test_done;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Core side push into the scan-in buffer; caller knows it has room.
    task automatic push(input logic [7:0] d);
        @(negedge sys_clk);
        scan_in_data = d;
        scan_in_valid = 1'b1;
        @(negedge sys_clk);
        scan_in_valid = 1'b0;
        scan_in_data = ~d;
    endtask

    // Core side pop of one scan-out byte with its value checked.
    task automatic pop(input logic [7:0] d);
        @(negedge sys_clk);
        check(scan_out_data, d);
        check_flag(scan_out_valid, 1'b1);
        scan_out_ready = 1'b1;
        @(negedge sys_clk);
        scan_out_ready = 1'b0;
    endtask

    // Inputs move at falling edges, so rising edges see them settled.
    always @(posedge sys_clk) begin
        check_flag(host_data_oe, read_select & ~access_strobe_n);
        if (soft_reset_pulse === 1'b1) soft_seen <= 1'b1;
        if (ready === 1'b0) stalls <= stalls + 1;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        err_count++;
        test_done();
    end

    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 7; i++) begin
            host_u.access(1'b0, rows[i].a, rows[i].d, 300, rd_q, ok);
            check_flag(ok, 1'b1);
            host_u.access(1'b1, rows[i].a, 8'h00, 300, rd_q, ok);
            check(rd_q, rows[i].q);
        end
        // Second reset in mid-run, then every register outside the scan buffers.
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        foreach (rst_addr[i]) begin
            host_u.access(1'b1, rst_addr[i], 8'h00, 300, rd_q, ok);
            check(rd_q, rst_val[i]);
        end
        // Empty scan-in read waits for the core's byte.
        stalls = 0;
        fork
            host_u.access(1'b1, ADDR_SCAN_IN, 8'h00, 300, rd_q, ok);
            begin repeat (30) @(negedge sys_clk); push(8'h3c); end
        join
        check(rd_q, 8'h3c);
        check_flag(ok && stalls > 20, 1'b1);
        push(8'h11);
        push(8'h22);
        check_flag(scan_in_ready, 1'b0);
        host_u.access(1'b1, ADDR_SCAN_IN, 8'h00, 300, rd_q, ok);
        check(rd_q, 8'h11);
        host_u.access(1'b1, ADDR_SCAN_IN, 8'h00, 300, rd_q, ok);
        check(rd_q, 8'h22);
        // Full scan-out buffer stalls the third write until a pop.
        host_u.access(1'b0, ADDR_SCAN_OUT, 8'h41, 300, rd_q, ok);
        host_u.access(1'b0, ADDR_SCAN_OUT, 8'h42, 300, rd_q, ok);
        stalls = 0;
        fork
            host_u.access(1'b0, ADDR_SCAN_OUT, 8'h43, 300, rd_q, ok);
            begin repeat (30) @(negedge sys_clk); pop(8'h41); end
        join
        check_flag(ok && stalls > 20, 1'b1);
        pop(8'h42);
        pop(8'h43);
        check_flag(scan_out_valid, 1'b0);
        // Buffer reset in progress also holds a write off.
        tx_resetting = 1'b1;
        stalls = 0;
        fork
            host_u.access(1'b0, ADDR_SCAN_OUT, 8'h44, 300, rd_q, ok);
            begin repeat (30) @(negedge sys_clk); tx_resetting = 1'b0; end
        join
        check_flag(ok && stalls > 20, 1'b1);
        pop(8'h44);
        // Running command: setup write waits, discrete write is dropped.
        host_u.access(1'b0, ADDR_OP_CONTROL, 8'h01, 300, rd_q, ok);
        stalls = 0;
        fork
            host_u.access(1'b0, ADDR_SETUP_PRIMARY, 8'h2a, 300, rd_q, ok);
            begin
                repeat (30) @(negedge sys_clk);
                command_done = 1'b1;
                @(negedge sys_clk);
                command_done = 1'b0;
            end
        join
        check_flag(ok && stalls > 20, 1'b1);
        host_u.access(1'b1, ADDR_SETUP_PRIMARY, 8'h00, 300, rd_q, ok);
        check(rd_q, 8'h2a);
        host_u.access(1'b1, ADDR_OP_CONTROL, 8'h00, 300, rd_q, ok);
        check(rd_q, 8'h00);
        host_u.access(1'b0, ADDR_OP_CONTROL, 8'h01, 300, rd_q, ok);
        host_u.access(1'b0, ADDR_MANUAL_PIN, 8'h05, 300, rd_q, ok);
        host_u.access(1'b1, ADDR_MANUAL_PIN, 8'h00, 300, rd_q, ok);
        check(rd_q, 8'h00);
        host_u.access(1'b0, ADDR_OP_CONTROL, 8'h80, 20, rd_q, ok);
        check_flag(ok & soft_seen, 1'b1);
        host_u.access(1'b1, ADDR_OP_CONTROL, 8'h00, 300, rd_q, ok);
        check(rd_q, 8'h00);
        // Full duplex with retiming: five writes pass, the sixth hangs.
        host_u.access(1'b0, ADDR_SETUP_SECONDARY, 8'h83, 300, rd_q, ok);
        full_duplex_active = 1'b1;
        scan_out_ready = 1'b1;
        for (int i = 0; i < 5; i++) begin
            host_u.access(1'b0, ADDR_SCAN_OUT, 8'h50, 300, rd_q, ok);
            check_flag(ok, 1'b1);
        end
        host_u.access(1'b0, ADDR_SCAN_OUT, 8'h56, 60, rd_q, ok);
        check_flag(ok, 1'b0);
        full_duplex_active = 1'b0;
        scan_out_ready = 1'b0;
        test_done();
    end
endmodule
